// ===== xbus_consts.vh
// Constants for the X-Bus peripheral decode block
// Operation
// (RULE1) Floppy range bit picks primary or secondary
// (RULE2) Drive-interface read returns inverted disk change
// (RULE3) Disk change low at reset disables floppy
// (RULE4) Either light bit asserts disk light low
// (RULE5) Config RAM: 32 pages of 256 bytes
// (RULE6) Page bits drive upper address in window
// (RULE7) Read/write strobes for window I/O cycles
// (RULE8) Page drive and strobes need enable bit
// (RULE9) Mode bit: separate selects or encoded code
// (RULE10) GP window: base low/high, mask, 1-256 bytes
// (RULE11) Encoded mode decodes GP0/1, IDE, parallel, serial
// (RULE12) Codes 000..110 per device, 111 idle
// (RULE13) Four bits route serial ranges to A or B
// (RULE14) Direction high for reads toward system data
// (RULE15) Buffer enable for enabled peripheral I/O cycles
// (RULE16) GP match ignores masked address bits
// (RULE17) One code per cycle, lowest code wins
`ifndef XBUS_CONSTS_VH
`define XBUS_CONSTS_VH
`define FLOPPY_PRI_BASE    16'h03f0
`define FLOPPY_SEC_BASE    16'h0370
`define FLOPPY_DIR_LOW     3'h7
`define CFG_RAM_BASE       8'h08
`define CFG_PAGE_PORT      16'h0c00
`define SERIAL1_BASE       16'h03f8
`define SERIAL2_BASE       16'h02f8
`define PARALLEL_BASE      16'h0378
`define IDE0_BASE          16'h01f0
`define IDE1_BASE          16'h03f6
`define PCSA_FLOPPY_EN     0
`define PCSA_FLOPPY_SEC    5
`define PCSB_SER1_EN       0
`define PCSB_SER1_TO_B     1
`define PCSB_SER2_EN       2
`define PCSB_SER2_TO_B     3
`define PCSB_PARALLEL_EN   4
`define PCSB_IDE_EN        5
`define PCSB_CFG_RAM_EN    7
`define CODE_SERIAL_A      3'h0
`define CODE_SERIAL_B      3'h1
`define CODE_PARALLEL      3'h2
`define CODE_IDE0          3'h3
`define CODE_IDE1          3'h4
`define CODE_GP0           3'h5
`define CODE_GP1           3'h6
`define CODE_IDLE          3'h7
`define PAGE_RESET         8'h00
`endif

// ===== xbus_peripheral_decode.v
// X-Bus peripheral chip select, config RAM and buffer control
`include "xbus_consts.vh"
`default_nettype none
module xbus_peripheral_decode #(
   parameter GP_COUNT = 3
) (
   input  wire                  ref_clk,
   input  wire                  rst,
   input  wire [15:0]           ioAddr,
   input  wire                  ioRead,
   input  wire                  ioWrite,
   input  wire                  memRead,
   input  wire                  dmaWrite,
   input  wire                  dmaRead,
   input  wire                  biosHit,
   input  wire [7:0]            sdIn,
   input  wire                  disk_change_n,
   input  wire [1:0]            diskLightBits,
   input  wire [7:0]            periphSelA,
   input  wire [7:0]            periphSelB,
   input  wire                  modeEncoded,
   input  wire [GP_COUNT-1:0]   gpEnable,
   input  wire [8*GP_COUNT-1:0] gpBaseLow,
   input  wire [8*GP_COUNT-1:0] gpBaseHigh,
   input  wire [8*GP_COUNT-1:0] gpMask,
   output reg  [7:0]            sdOut,
   output reg  [7:0]            sdOutEn_n,
   output reg                   floppy_select_n,
   output reg                   disk_light_n,
   output reg                   cfg_ram_read_n,
   output reg                   cfg_ram_write_n,
   output reg  [4:0]            pageAddr,
   output reg                   pageAddrEn_n,
   output reg  [2:0]            gp_select_n,
   output reg                   xbuf_direction,
   output reg                   xbuf_output_enable_n,
   output reg                   floppyPresent
);

   // ------------------------------------------------------------
   // Address helpers
   // ------------------------------------------------------------
   function inRange8;
      input [15:0] addr;
      input [15:0] base;
      begin
         inRange8 = (addr[15:3] == base[15:3]);
      end
   endfunction

   function gpHit;
      input [15:0] addr;
      input [7:0]  lo;
      input [7:0]  hi;
      input [7:0]  mask;
      begin
         gpHit = (((addr ^ {hi, lo}) & ~{8'h00, mask}) == 16'h0000);
      end
   endfunction

   // ------------------------------------------------------------
   // Floppy presence strap
   // ------------------------------------------------------------
   // Strap caught by the clock, never by the async reset itself;
   // the first edge after release still sees the reset-time level.
   reg strapDone_q;
   reg floppyPresent_q;

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         strapDone_q     <= 1'b0;
         floppyPresent_q <= 1'b0;
      end else if (!strapDone_q) begin
         strapDone_q     <= 1'b1;
         floppyPresent_q <= disk_change_n; // [RULE3]
      end
   end

   // ------------------------------------------------------------
   // Config RAM page register
   // ------------------------------------------------------------
   reg  [7:0] page_q;
   wire       pageHit = (ioAddr == `CFG_PAGE_PORT);

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         page_q <= `PAGE_RESET;
      end else if (ioWrite && pageHit) begin
         page_q <= sdIn;
      end
   end

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   wire ioCycle = ioRead | ioWrite;
   wire floppySec = periphSelA[`PCSA_FLOPPY_SEC];
   wire [15:0] floppyBase = floppySec ? `FLOPPY_SEC_BASE
                                      : `FLOPPY_PRI_BASE; // [RULE1]
   wire floppyOn = periphSelA[`PCSA_FLOPPY_EN] & floppyPresent_q;
   wire floppyHit = floppyOn & inRange8(ioAddr, floppyBase); // [RULE3]
   wire dirHit = floppyHit
               & (ioAddr[2:0] == `FLOPPY_DIR_LOW); // [RULE2]

   // Window of 256 bytes, page picks one of 32 banks
   wire cfgOn  = periphSelB[`PCSB_CFG_RAM_EN]; // [RULE8]
   wire cfgHit = cfgOn
               & (ioAddr[15:8] == `CFG_RAM_BASE); // [RULE5]

   wire ser1 = periphSelB[`PCSB_SER1_EN]
             & inRange8(ioAddr, `SERIAL1_BASE);
   wire ser2 = periphSelB[`PCSB_SER2_EN]
             & inRange8(ioAddr, `SERIAL2_BASE);
   wire serA = (ser1 & ~periphSelB[`PCSB_SER1_TO_B])
             | (ser2 & ~periphSelB[`PCSB_SER2_TO_B]); // [RULE13]
   wire serB = (ser1 & periphSelB[`PCSB_SER1_TO_B])
             | (ser2 & periphSelB[`PCSB_SER2_TO_B]); // [RULE13]
   wire parHit = periphSelB[`PCSB_PARALLEL_EN]
               & inRange8(ioAddr, `PARALLEL_BASE);
   wire ide0 = periphSelB[`PCSB_IDE_EN]
             & inRange8(ioAddr, `IDE0_BASE);
   // Two-byte range, so only bit 0 is ignored
   wire [15:0] ide1Base = `IDE1_BASE;
   wire ide1 = periphSelB[`PCSB_IDE_EN]
             & (ioAddr[15:1] == ide1Base[15:1]);

   wire [GP_COUNT-1:0] gpMatch;
   genvar g;
   generate
      for (g = 0; g < GP_COUNT; g = g + 1) begin : gpDecode
         assign gpMatch[g] = gpEnable[g]
            & gpHit(ioAddr, gpBaseLow[8*g+7:8*g],
                    gpBaseHigh[8*g+7:8*g],
                    gpMask[8*g+7:8*g]); // [RULE10] [RULE16]
      end
   endgenerate

   // Lowest code wins when ranges overlap
   reg [2:0] code;
   always @* begin
      if (!ioCycle)
         code = `CODE_IDLE;
      else if (serA)
         code = `CODE_SERIAL_A; // [RULE17]
      else if (serB)
         code = `CODE_SERIAL_B;
      else if (parHit)
         code = `CODE_PARALLEL;
      else if (ide0)
         code = `CODE_IDE0;
      else if (ide1)
         code = `CODE_IDE1;
      else if (gpMatch[0])
         code = `CODE_GP0; // [RULE11]
      else if (gpMatch[1])
         code = `CODE_GP1;
      else
         code = `CODE_IDLE; // [RULE12]
   end

   wire anyPeriph = floppyHit | serA | serB | parHit | ide0 | ide1
                  | (|gpMatch) | cfgHit;

   // ------------------------------------------------------------
   // Output registers
   // ------------------------------------------------------------
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sdOut                <= 8'h00;
         sdOutEn_n            <= 8'hff;
         floppy_select_n      <= 1'b1;
         disk_light_n         <= 1'b1;
         cfg_ram_read_n       <= 1'b1;
         cfg_ram_write_n      <= 1'b1;
         pageAddr             <= 5'h00;
         pageAddrEn_n         <= 1'b1;
         gp_select_n          <= 3'h7;
         xbuf_direction       <= 1'b0;
         xbuf_output_enable_n <= 1'b1;
         floppyPresent        <= 1'b0;
      end else begin
         floppyPresent   <= floppyPresent_q;
         floppy_select_n <= ~(ioCycle & floppyHit); // [RULE1]
         disk_light_n    <= ~(|diskLightBits); // [RULE4]
         cfg_ram_read_n  <= ~(ioRead & cfgHit); // [RULE7]
         cfg_ram_write_n <= ~(ioWrite & cfgHit); // [RULE7]
         pageAddr        <= page_q[4:0]; // [RULE6]
         pageAddrEn_n    <= ~(ioCycle & cfgHit); // [RULE6]
         // Floppy readback drives only bit 7; rest stays released
         if (ioRead && pageHit) begin
            sdOut     <= page_q;
            sdOutEn_n <= 8'h00;
         end else if (ioRead && dirHit) begin
            sdOut     <= {~disk_change_n, 7'h00}; // [RULE2]
            sdOutEn_n <= 8'h7f;
         end else begin
            sdOut     <= 8'h00;
            sdOutEn_n <= 8'hff;
         end
         if (modeEncoded)
            gp_select_n <= code; // [RULE9]
         else
            gp_select_n <= ~({3{ioCycle}} & gpMatch[2:0]); // [RULE9]
         xbuf_direction <= ioRead | dmaWrite
                         | ((memRead | dmaRead) & biosHit); // [RULE14]
         xbuf_output_enable_n <= ~(ioCycle & anyPeriph); // [RULE15]
      end
   end

endmodule
`default_nettype wire

// ===== xbus_decode_checker.sv
// Port-level assertions for the X-Bus peripheral decode block
`default_nettype none
module xbus_decode_checker #(parameter GP_COUNT = 3) (
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire logic [15:0] ioAddr,
   input wire logic        ioRead,
   input wire logic        ioWrite,
   input wire logic        memRead,
   input wire logic        dmaWrite,
   input wire logic        dmaRead,
   input wire logic        biosHit,
   input wire logic        disk_change_n,
   input wire logic [1:0]  diskLightBits,
   input wire logic [7:0]  periphSelA,
   input wire logic [7:0]  periphSelB,
   input wire logic        modeEncoded,
   input wire logic [7:0]  sdOut,
   input wire logic        floppy_select_n,
   input wire logic        disk_light_n,
   input wire logic        cfg_ram_read_n,
   input wire logic        cfg_ram_write_n,
   input wire logic        pageAddrEn_n,
   input wire logic [2:0]  gp_select_n,
   input wire logic        xbuf_direction,
   input wire logic        floppyPresent
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_floppy_range:
   assert property (ioRead && periphSelA[0] && floppyPresent && ioAddr[15:3]
      == (periphSelA[5] ? 13'h6e : 13'h7e) |=> !floppy_select_n)
      else $error("floppy select missing");
   a_floppy_off:
   assert property (!floppyPresent || !periphSelA[0] |=> floppy_select_n)
      else $error("floppy select while disabled");
   a_change_read:
   assert property (ioRead && ioAddr == 16'h03f7 && periphSelA[0]
      && !periphSelA[5] && floppyPresent
      |=> sdOut[7] == !$past(disk_change_n))
      else $error("disk change readback wrong");
   a_light_follow:
   assert property (!$past(rst)
      |-> disk_light_n == ($past(diskLightBits) == 2'h0))
      else $error("disk light wrong");
   a_cfg_read:
   assert property (ioRead && ioAddr[15:8] == 8'h08 && periphSelB[7]
      |=> !cfg_ram_read_n && !pageAddrEn_n)
      else $error("config read strobe missing");
   a_cfg_write:
   assert property (ioWrite && ioAddr[15:8] == 8'h08 && periphSelB[7]
      |=> !cfg_ram_write_n) else $error("config write strobe missing");
   a_cfg_gate:
   assert property (!periphSelB[7] |=> cfg_ram_read_n && cfg_ram_write_n
      && pageAddrEn_n) else $error("config RAM active while off");
   a_code_idle:
   assert property (modeEncoded && !ioRead && !ioWrite
      |=> gp_select_n == 3'h7) else $error("encoded code not idle");
   a_read_dir:
   assert property (ioRead || dmaWrite || biosHit && (memRead || dmaRead)
      |=> xbuf_direction) else $error("buffer direction low");
   c_floppy: cover property (!floppy_select_n);
   c_cfg_rd: cover property (!cfg_ram_read_n);
   c_gp_code: cover property (modeEncoded ##1 gp_select_n == 3'h5);
endmodule
bind xbus_peripheral_decode xbus_decode_checker
   #(.GP_COUNT(GP_COUNT)) xbus_decode_checker_i (.*);
`default_nettype wire

// ===== xbus_far_side.sv
// Floppy drive stand-in that drives the disk change line
`default_nettype none
module xbus_far_side (
   input  wire logic swapped,
   output logic      disk_change_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // Level only: the drive holds it low for as long as swapped stays high
   assign disk_change_n = !swapped;
endmodule
`default_nettype wire

// ===== xbus_peripheral_decode_tb_top.sv
// Self-checking bench for the X-Bus peripheral decode block
`default_nettype none
module xbus_peripheral_decode_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk = 0, rst = 1, ioRead = 0, ioWrite = 0, swapped = 0;
   logic        memRead = 0, dmaWrite = 0, dmaRead = 0, biosHit = 0;
   logic        modeEncoded = 0;
   logic [15:0] ioAddr = 16'h0000, dv = 16'h2459;
   logic [7:0]  sdIn = 8'h00, periphSelA = 8'h01, periphSelB = 8'h00;
   logic [1:0]  diskLightBits = 2'h0;
   logic [2:0]  gpEnable = 3'h7, gp_select_n;
   logic [23:0] gpBaseLow = 24'h201000, gpBaseHigh = 24'h030303;
   logic [23:0] gpMask = 24'h000007;
   logic [7:0]  sdOut, sdOutEn_n;
   logic [4:0]  pageAddr;
   logic        disk_change_n, floppy_select_n, disk_light_n, pageAddrEn_n;
   logic        cfg_ram_read_n, cfg_ram_write_n, floppyPresent;
   logic        xbuf_direction, xbuf_output_enable_n;
   logic [15:0] ea [13] = '{16'h03f8, 16'h02f8, 16'h0378, 16'h01f0,
      16'h03f6, 16'h0305, 16'h0310, 16'h0311, 16'h0308, 16'h0305,
      16'h0310, 16'h0320, 16'h0321};
   logic [2:0]  ec [13] = '{3'h1, 3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6,
      3'h7, 3'h7, 3'h6, 3'h5, 3'h3, 3'h7};
   int          bad_count = 0, checked = 0;
   xbus_peripheral_decode #(.GP_COUNT(3)) xbus_peripheral_decode_i (.*);
   xbus_far_side xbus_far_side_i (.*);
   initial forever #2 ref_clk = ~ref_clk;
   // ----------------------------------------
   // Bus cycle and compare helpers
   // ----------------------------------------
   // Request held over one sampling edge; outputs lag it by one edge
   task automatic io(input logic r, w, input logic [15:0] a,
                     input logic [7:0] d = 8'h00);
      @(posedge ref_clk);
      ioRead <= r;
      ioWrite <= w;
      ioAddr <= a;
      sdIn <= d;
      @(posedge ref_clk);
      #1;
   endtask
   task automatic chk(input string n, input logic [7:0] e, g);
      checked++;
      if (g !== e) begin
         $display("MISMATCH %s exp %h got %h", n, e, g);
         bad_count++;
      end
   endtask
   task automatic end_sim();
      if (bad_count == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      #20000;
      bad_count++;
      end_sim();
   end
   initial begin
      repeat (12) @(posedge ref_clk);
      rst <= 0;
      repeat (2) @(posedge ref_clk);
      io(1, 0, 16'h0c00);
      chk("page", 8'h00, sdOut);
      io(1, 0, 16'h03f7);
      chk("fsel", 0, floppy_select_n);
      chk("sd7", 0, sdOut[7]);
      @(posedge ref_clk) swapped <= 1;
      io(1, 0, 16'h03f7);
      chk("sd7", 1, sdOut[7]);
      io(1, 0, 16'h0377);
      chk("fsel", 1, floppy_select_n);
      @(posedge ref_clk) periphSelA <= 8'h21;
      io(1, 0, 16'h0377);
      chk("fsel", 0, floppy_select_n);
      chk("sd7", 1, sdOut[7]);
      @(posedge ref_clk) swapped <= 0;
      io(1, 0, 16'h03f7);
      chk("fsel", 1, floppy_select_n);
      for (int i = 0; i < 4; i++) begin
         @(posedge ref_clk) diskLightBits <= i[1:0];
         io(0, 0, 16'h0000);
         chk("light", i == 0, disk_light_n);
      end
      @(posedge ref_clk) periphSelB <= 8'h80;
      io(0, 1, 16'h0c00, 8'hb5);
      io(1, 0, 16'h0812);
      chk("crd", 0, cfg_ram_read_n);
      chk("page", 8'h15, pageAddr);
      chk("pen", 0, pageAddrEn_n);
      io(0, 1, 16'h08ff);
      chk("cwr", 0, cfg_ram_write_n);
      io(1, 0, 16'h0900);
      chk("crd", 1, cfg_ram_read_n);
      io(1, 0, 16'h0c00);
      chk("page", 8'hb5, sdOut);
      @(posedge ref_clk);
      periphSelB <= 8'h37;
      modeEncoded <= 1;
      io(1, 0, 16'h0800);
      chk("crd", 1, cfg_ram_read_n);
      for (int i = 0; i < 13; i++) begin
         if (i == 9) @(posedge ref_clk) modeEncoded <= 0;
         io(1, 0, ea[i]);
         chk("code", ec[i], gp_select_n);
      end
      for (int i = 0; i < 4; i++) begin
         @(posedge ref_clk)
            {memRead, dmaRead, dmaWrite, biosHit} <= dv[i*4+:4];
         io(0, 0, 16'h0000);
         chk("dir", i != 2, xbuf_direction);
      end
      io(1, 0, 16'h0378);
      chk("oe", 0, xbuf_output_enable_n);
      @(posedge ref_clk) periphSelB <= 8'h27;
      io(1, 0, 16'h0378);
      chk("oe", 1, xbuf_output_enable_n);
      @(posedge ref_clk);
      rst <= 1;
      swapped <= 1;
      repeat (3) @(posedge ref_clk);
      rst <= 0;
      repeat (2) @(posedge ref_clk);
      io(1, 0, 16'h0377);
      chk("fsel", 1, floppy_select_n);
      chk("sdoe", 1, sdOutEn_n[7]);
      chk("present", 0, floppyPresent);
      end_sim();
   end
endmodule
`default_nettype wire
